// >>> logic/acs_pkg.sv
// shared constants and types for the conversion sequencer
package acs_pkg;
  localparam int AW = 4;
  localparam int DW = 16;

  // register offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] SEL_OFS  = 4'h1;
  localparam logic [3:0] STAT_OFS = 4'h2;
  localparam logic [3:0] RES_OFS  = 4'h3;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [6:0] SEL_RST  = 7'h00;

  // status field positions
  localparam int ST_DONE  = 0;
  localparam int ST_BUSY  = 1;
  localparam int ST_INVAL = 2;
  localparam int ST_HALF  = 3;
  localparam int ST_ACT   = 4;

  // conversion lengths and sample points, in half converter cycles
  localparam logic [5:0] LEN_FIRST = 6'h32;
  localparam logic [5:0] LEN_NORM  = 6'h1A;
  localparam logic [5:0] LEN_DIFF  = 6'h1C;
  localparam logic [5:0] LEN_AUTO  = 6'h1B;
  localparam logic [5:0] SMP_FIRST = 6'h1D;
  localparam logic [5:0] SMP_NORM  = 6'h03;
  localparam logic [5:0] SMP_DIFF  = 6'h05;
  localparam logic [5:0] SMP_AUTO  = 6'h04;
  // final converter cycle, in half cycles, where the selection copy resumes
  localparam logic [5:0] LAST_CYC  = 6'h02;

  localparam int TRIG_SYNC = 3;

  typedef enum logic [1:0] {ST_IDLE, ST_PEND, ST_CONV} acs_state_e;

  typedef struct packed {
    logic [2:0] prescale;
    logic       irq_en;
    logic       free_run;
    logic       auto_trig;
    logic       start;
    logic       enable;
  } acs_ctrl_s;

  typedef struct packed {
    logic [1:0] ref_sel;
    logic [4:0] chan;
  } acs_sel_s;

  typedef struct packed {
    logic [5:0] len;
    logic [5:0] smp;
  } acs_timing_s;
endpackage

// >>> logic/acs_prescaler.sv
// converter clock prescaler with half-rate sample clock
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic       restart_i,
  input  wire logic [2:0] div_sel_i,
  output logic            rise_o,
  output logic            fall_o,
  output logic            half_o
);
  logic [6:0] cnt_reg;
  logic [7:0] div;
  logic [6:0] top;
  logic [6:0] mid;

  // division by 2^sel, select zero also divides by two
  assign div = 8'h01 << ((div_sel_i == 3'h0) ? 3'h1 : div_sel_i);
  assign top = 7'(div - 8'h01);
  assign mid = 7'((div >> 1) - 8'h01);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 7'h00;
    end else if (!run_i || restart_i) begin
      cnt_reg <= 7'h00;
    end else if (cnt_reg == top) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= run_i && !restart_i && (cnt_reg == top);
      fall_o <= run_i && !restart_i && (cnt_reg == mid);
    end
  end

  // toggle on each rise, cleared with the prescaler
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      half_o <= 1'b0;
    end else if (!run_i || restart_i) begin
      half_o <= 1'b0;
    end else if (rise_o) begin
      half_o <= !half_o;
    end
  end
endmodule
`default_nettype wire

// >>> logic/acs_sequencer.sv
// conversion sequencer top: timing, selection buffering, sleep start
//
// Behaviour
// - single-ended conversion samples at 1.5 cycles, finishes after 13 cycles.
// - first conversion after enabling lasts 25 converter cycles.
// - triggered conversion samples 2 cycles after edge; trigger sync takes 3 clocks.
// - prescaler runs only while enabled, held in reset otherwise.
// - on completion store result, set done flag, clear start in single mode.
// - differential conversions align to the half-rate sample clock.
// - differential start while half clock low takes 13 cycles.
// - differential start while half clock high takes 14 cycles.
// - free running restarts at once; later differential runs take 14 cycles.
// - trigger resets prescaler first; differential result then marked invalid, except the first after enabling.
// - selection buffered, copied continuously, frozen once conversion starts.
// - copying resumes in the last converter cycle before completion.
// - software start begins at the next converter clock rise.
// - free run channel change: next result old channel, later ones new.
// - sleep halt starts a conversion when enabled, idle, single, irq on.
// - conversion still completes and requests interrupt after early wake.
// - sleep never clears enable; only software does.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer (
  input  wire logic                   CLOCK_I,
  input  wire logic                   RST_N_I,
  input  wire logic [acs_pkg::AW-1:0] ADDR_I,
  input  wire logic [acs_pkg::DW-1:0] WDATA_I,
  input  wire logic                   WR_I,
  input  wire logic                   RD_I,
  output logic      [acs_pkg::DW-1:0] RDATA_O,
  input  wire logic                   TRIG_I,
  input  wire logic                   CPU_HALT_I,
  input  wire logic [9:0]             SAR_RESULT_I,
  output logic                        SAMPLE_O,
  output logic                        CONV_BUSY_O,
  output logic                        DIFF_MODE_O,
  output logic      [4:0]             ACT_CHAN_O,
  output logic      [1:0]             ACT_REF_O,
  output logic                        DONE_IRQ_O
);
  acs_pkg::acs_ctrl_s   ctrl_reg;
  acs_pkg::acs_ctrl_s   wctl;
  acs_pkg::acs_sel_s    sel_reg;
  acs_pkg::acs_sel_s    act_reg;
  acs_pkg::acs_timing_s tim_reg;
  acs_pkg::acs_timing_s tim_next;
  acs_pkg::acs_state_e  st_reg;
  logic [5:0]           hcnt_reg;
  logic [9:0]           res_reg;
  logic                 done_reg;
  logic                 inval_reg;
  logic                 first_reg;
  logic                 halt_reg;
  logic [acs_pkg::TRIG_SYNC-1:0] trig_sync_reg;
  logic                 trig_lvl_reg;
  logic                 rise;
  logic                 fall;
  logic                 half;
  logic                 tick;
  logic                 wr_ctrl;
  logic                 trig_edge;
  logic                 trig_start;
  logic                 sleep_start;
  logic                 done_now;
  logic                 free_run;
  logic                 diff_sel;
  logic                 locked;

  assign wctl     = acs_pkg::acs_ctrl_s'(WDATA_I[7:0]);
  assign wr_ctrl  = WR_I && (ADDR_I == acs_pkg::CTRL_OFS);
  assign tick     = rise || fall;
  assign free_run = ctrl_reg.auto_trig && ctrl_reg.free_run;
  // channel codes 8..29 are differential pairs; 30, 31 are fixed sources
  assign diff_sel = (act_reg.chan[4:3] != 2'h0) && (act_reg.chan[4:1] != 4'hF);
  assign done_now = (st_reg == acs_pkg::ST_CONV) && tick
                    && (hcnt_reg == tim_reg.len - 6'h01);
  assign locked   = (st_reg == acs_pkg::ST_CONV)
                    && (hcnt_reg < tim_reg.len - acs_pkg::LAST_CYC);

  acs_prescaler u_presc (
    .clk_i     (CLOCK_I),
    .rst_n_i   (RST_N_I),
    .run_i     (ctrl_reg.enable),
    .restart_i (trig_start),
    .div_sel_i (ctrl_reg.prescale),
    .rise_o    (rise),
    .fall_o    (fall),
    .half_o    (half)
  );

  // trigger pin: three stages, a level counts once the last two agree
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trig_sync_reg <= '0;
      trig_lvl_reg  <= 1'b0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[acs_pkg::TRIG_SYNC-2:0], TRIG_I};
      if (trig_sync_reg[2] == trig_sync_reg[1]) begin
        trig_lvl_reg <= trig_sync_reg[2];
      end
    end
  end

  assign trig_edge  = (trig_sync_reg[2] == trig_sync_reg[1])
                      && trig_sync_reg[2] && !trig_lvl_reg;
  // edges during a conversion are ignored; free run needs no trigger
  assign trig_start = ctrl_reg.enable && ctrl_reg.auto_trig && !ctrl_reg.free_run
                      && (st_reg == acs_pkg::ST_IDLE) && trig_edge;
  assign sleep_start = CPU_HALT_I && !halt_reg && ctrl_reg.enable
                       && (st_reg == acs_pkg::ST_IDLE) && !ctrl_reg.start
                       && !ctrl_reg.auto_trig && ctrl_reg.irq_en;

  // length and sample point for a conversion begun this cycle
  always_comb begin
    if (first_reg) begin
      tim_next = '{len: acs_pkg::LEN_FIRST, smp: acs_pkg::SMP_FIRST};
    end else if (trig_start) begin
      tim_next = '{len: acs_pkg::LEN_AUTO, smp: acs_pkg::SMP_AUTO};
    end else if (diff_sel && half) begin
      tim_next = '{len: acs_pkg::LEN_DIFF, smp: acs_pkg::SMP_DIFF};
    end else begin
      tim_next = '{len: acs_pkg::LEN_NORM, smp: acs_pkg::SMP_NORM};
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      halt_reg <= 1'b0;
    end else begin
      halt_reg <= CPU_HALT_I;
    end
  end

  // control register; only software ever clears enable
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_reg <= acs_pkg::acs_ctrl_s'(acs_pkg::CTRL_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wctl;
      end
      if (wr_ctrl && wctl.start && wctl.enable) begin
        ctrl_reg.start <= 1'b1;
      end else if (wr_ctrl && !wctl.enable) begin
        ctrl_reg.start <= 1'b0;
      end else if (sleep_start || trig_start) begin
        ctrl_reg.start <= 1'b1;
      end else if (done_now && !free_run) begin
        ctrl_reg.start <= 1'b0;
      end else begin
        ctrl_reg.start <= ctrl_reg.start;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sel_reg <= acs_pkg::acs_sel_s'(acs_pkg::SEL_RST);
    end else if (WR_I && (ADDR_I == acs_pkg::SEL_OFS)) begin
      sel_reg <= acs_pkg::acs_sel_s'(WDATA_I[6:0]);
    end
  end

  // active selection follows the buffer except while locked
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      act_reg <= acs_pkg::acs_sel_s'(acs_pkg::SEL_RST);
    end else if (!locked) begin
      act_reg <= sel_reg;
    end
  end

  // conversion sequence
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_reg   <= acs_pkg::ST_IDLE;
      hcnt_reg <= 6'h00;
      tim_reg  <= '{len: acs_pkg::LEN_NORM, smp: acs_pkg::SMP_NORM};
    end else if (!ctrl_reg.enable) begin
      st_reg   <= acs_pkg::ST_IDLE;
      hcnt_reg <= 6'h00;
    end else begin
      unique case (st_reg)
        acs_pkg::ST_IDLE: begin
          if (trig_start) begin
            st_reg   <= acs_pkg::ST_CONV;
            hcnt_reg <= 6'h00;
            tim_reg  <= tim_next;
          end else if (ctrl_reg.start) begin
            st_reg <= acs_pkg::ST_PEND;
          end
        end
        acs_pkg::ST_PEND: begin
          if (rise) begin
            st_reg   <= acs_pkg::ST_CONV;
            hcnt_reg <= 6'h00;
            tim_reg  <= tim_next;
          end
        end
        acs_pkg::ST_CONV: begin
          if (done_now && free_run) begin
            hcnt_reg <= 6'h00;
            tim_reg  <= tim_next;
          end else if (done_now) begin
            st_reg <= acs_pkg::ST_IDLE;
          end else if (tick) begin
            hcnt_reg <= hcnt_reg + 6'h01;
          end
        end
      endcase
    end
  end

  // first conversion after enabling runs the long initialisation
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      first_reg <= 1'b1;
    end else if (!ctrl_reg.enable) begin
      first_reg <= 1'b1;
    end else if (done_now) begin
      first_reg <= 1'b0;
    end
  end

  // done and invalid flags: write one clears, a new event wins
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      done_reg  <= 1'b0;
      inval_reg <= 1'b0;
      res_reg   <= 10'h000;
    end else begin
      if (done_now) begin
        done_reg <= 1'b1;
        res_reg  <= SAR_RESULT_I;
      end else if (WR_I && (ADDR_I == acs_pkg::STAT_OFS) && WDATA_I[acs_pkg::ST_DONE]) begin
        done_reg <= 1'b0;
      end
      if (trig_start && diff_sel && !first_reg) begin
        inval_reg <= 1'b1;
      end else if (WR_I && (ADDR_I == acs_pkg::STAT_OFS) && WDATA_I[acs_pkg::ST_INVAL]) begin
        inval_reg <= 1'b0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SAMPLE_O    <= 1'b0;
      CONV_BUSY_O <= 1'b0;
      DIFF_MODE_O <= 1'b0;
      ACT_CHAN_O  <= 5'h00;
      ACT_REF_O   <= 2'h0;
      DONE_IRQ_O  <= 1'b0;
    end else begin
      SAMPLE_O    <= (st_reg == acs_pkg::ST_CONV) && tick
                     && (hcnt_reg == tim_reg.smp - 6'h01);
      CONV_BUSY_O <= (st_reg == acs_pkg::ST_CONV);
      DIFF_MODE_O <= diff_sel;
      ACT_CHAN_O  <= act_reg.chan;
      ACT_REF_O   <= act_reg.ref_sel;
      // request stands while flag and enable are set, awake or not
      DONE_IRQ_O  <= done_reg && ctrl_reg.irq_en;
    end
  end

  // read port: data in the cycle after the strobe, zero elsewhere
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      unique case (ADDR_I)
        acs_pkg::CTRL_OFS: RDATA_O <= {8'h00, ctrl_reg.prescale, ctrl_reg.irq_en,
                                       ctrl_reg.free_run, ctrl_reg.auto_trig,
                                       ctrl_reg.start || (st_reg != acs_pkg::ST_IDLE),
                                       ctrl_reg.enable};
        acs_pkg::SEL_OFS:  RDATA_O <= {9'h000, sel_reg};
        acs_pkg::STAT_OFS: RDATA_O <= {5'h00, act_reg, half, inval_reg,
                                       (st_reg == acs_pkg::ST_CONV), done_reg};
        acs_pkg::RES_OFS:  RDATA_O <= {6'h00, res_reg};
        default:           RDATA_O <= '0;
      endcase
    end else begin
      RDATA_O <= '0;
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  norm_len_a: assert property ((st_reg == acs_pkg::ST_PEND) && rise && !first_reg
    && !(diff_sel && half) |=> tim_reg.len == 6'h1A && tim_reg.smp == 6'h03)
    else $error("normal conversion timing wrong");
  first_len_a: assert property ((st_reg == acs_pkg::ST_PEND) && rise && first_reg
    |=> tim_reg.len == 6'h32)
    else $error("first conversion not extended");
  trig_len_a: assert property (trig_start && !first_reg
    |=> st_reg == acs_pkg::ST_CONV && tim_reg.smp == 6'h04)
    else $error("triggered conversion timing wrong");
  presc_hold_a: assert property (!ctrl_reg.enable ##1 !ctrl_reg.enable
    |-> !rise && !fall && !half)
    else $error("prescaler runs while disabled");
  done_flag_a: assert property (done_now |=> done_reg && res_reg == $past(SAR_RESULT_I))
    else $error("completion not recorded");
  single_clr_a: assert property (done_now && !free_run && !wr_ctrl && !trig_start
    && !sleep_start |=> !ctrl_reg.start)
    else $error("start bit not cleared");
  diff_high_a: assert property ((st_reg == acs_pkg::ST_PEND) && rise && !first_reg
    && diff_sel && half |=> tim_reg.len == 6'h1C)
    else $error("differential sync cycle missing");
  trig_reset_a: assert property (trig_start |=> !rise [*2])
    else $error("prescaler not restarted by trigger");
  sel_lock_a: assert property (locked |=> $stable(act_reg))
    else $error("selection changed while locked");
  sel_resume_a: assert property (done_now |-> !locked ##1 act_reg == $past(sel_reg))
    else $error("selection not copied at end");
  sw_start_a: assert property ((st_reg == acs_pkg::ST_PEND) && rise && ctrl_reg.enable
    |=> st_reg == acs_pkg::ST_CONV && hcnt_reg == 6'h00)
    else $error("start not on converter rise");
  sleep_go_a: assert property (sleep_start |=> ctrl_reg.start)
    else $error("sleep halt did not start conversion");
  half_tog_a: assert property (rise && ctrl_reg.enable && !trig_start
    |=> half != $past(half))
    else $error("half-rate clock did not toggle");

  free_run_c: cover property (done_now && free_run);
  trig_conv_c: cover property (trig_start ##[1:400] done_now);
  sleep_conv_c: cover property (sleep_start ##[1:900] DONE_IRQ_O);
endmodule
`default_nettype wire

// >>> verification/acs_sar_model.sv
// behavioural model of the sample-and-hold and approximation array
`timescale 1ns/1ps
`default_nettype none
module acs_sar_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       sample_i,
  input  wire logic       busy_i,
  input  wire logic [4:0] chan_i,
  input  wire logic [1:0] ref_i,
  output logic      [9:0] result_o
);
  logic [9:0] held_reg;

  // code carries the sampled selection so the bench can tell which input was converted
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_reg <= 10'h000;
    end else if (sample_i) begin
      held_reg <= {3'h5, chan_i, ref_i};
    end
  end

  // outside a conversion the code is scrambled, so a late capture cannot pass
  assign result_o = busy_i ? held_reg : ~held_reg;
endmodule
`default_nettype wire

// >>> verification/acs_sequencer_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_bench;
  logic        clk, rst_n, wr, rd, trig, halt, sample, busy, diff, irq;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, d;
  logic [9:0]  sar;
  logic [4:0]  act_chan;
  logic [1:0]  act_ref;
  int          miscompares, total_checks, cyc, run_cnt, busy_len, smp_at, smp_last;
  int          smp_gap, n, lat;

  acs_sequencer dut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .TRIG_I(trig), .CPU_HALT_I(halt), .SAR_RESULT_I(sar),
    .SAMPLE_O(sample), .CONV_BUSY_O(busy), .DIFF_MODE_O(diff), .ACT_CHAN_O(act_chan),
    .ACT_REF_O(act_ref), .DONE_IRQ_O(irq)
  );

  acs_sar_model sar_model (
    .clk_i(clk), .rst_n_i(rst_n), .sample_i(sample), .busy_i(busy),
    .chan_i(act_chan), .ref_i(act_ref), .result_o(sar)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // busy run length, sample offset within a run, spacing of sample strobes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    run_cnt <= (busy === 1'b1) ? run_cnt + 1 : 0;
    if (busy !== 1'b1 && run_cnt != 0) begin
      busy_len <= run_cnt;
    end
    if (sample === 1'b1) begin
      smp_at <= run_cnt;
      smp_gap <= cyc - smp_last;
      smp_last <= cyc;
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_in(input int got, input int lo, input int hi, input string what);
    total_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("MISMATCH %0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask

  task automatic wait_idle;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    lat = n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    chk_in(lat, 0, 9, "busy rise wait");
    chk_in(n, 0, 399, "busy fall wait");
  endtask

  task automatic wait_done;
    n = 0;
    d = 16'h0000;
    while (d[0] !== 1'b1 && n < 400) begin
      rd_reg(4'h2, d);
      n++;
    end
    chk_in(n, 1, 399, "done wait");
  endtask

  task automatic trig_pulse;
    @(posedge clk);
    trig <= 1'b1;
    n = 0;
    while (sample !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    lat = n;
    chk_in(n, 1, 79, "trigger sample wait");
    @(posedge clk);
    trig <= 1'b0;
  endtask

  function automatic logic [15:0] code(input logic [4:0] ch, input logic [1:0] rf);
    return {6'h00, 3'h5, ch, rf};
  endfunction

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    $display("MISMATCH %0t run did not finish", $time);
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    {wr, rd, trig, halt} = 4'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped places, start refused while disabled
    for (int i = 0; i < 6; i++) begin
      rd_reg(i[3:0], d);
      chk(d, 16'h0000, "reset value");
    end
    wr_reg(4'h5, 16'hFFFF);
    wr_reg(4'h0, 16'h0002);
    rd_reg(4'h0, d);
    chk(d, 16'h0000, "start while disabled");
    rd_reg(4'h5, d);
    chk(d, 16'h0000, "unmapped write");
    $display("test registers done");
    // first conversion, selection frozen then released at the end
    wr_reg(4'h0, 16'h0021);
    wr_reg(4'h1, 16'h0043);
    rd_reg(4'h2, d);
    chk({9'h000, d[10:4]}, 16'h0043, "selection follows");
    wr_reg(4'h0, 16'h0023);
    repeat (4) @(posedge clk);
    wr_reg(4'h1, 16'h0046);
    rd_reg(4'h2, d);
    chk({9'h000, d[10:4]}, 16'h0043, "selection frozen");
    wait_idle();
    chk_in(busy_len, acs_pkg::LEN_FIRST - 1, acs_pkg::LEN_FIRST + 1, "first length");
    chk_in(smp_at, acs_pkg::SMP_FIRST - 2, acs_pkg::SMP_FIRST + 1, "first sample");
    rd_reg(4'h0, d);
    chk(d, 16'h0021, "start cleared");
    rd_reg(4'h2, d);
    chk(d & 16'h07F7, 16'h0461, "done and new selection");
    rd_reg(4'h3, d);
    chk(d, code(5'h03, 2'h2), "first result");
    wr_reg(4'h2, 16'h0001);
    $display("test first conversion done");
    // normal single-ended conversion
    wr_reg(4'h0, 16'h0023);
    wait_idle();
    chk_in(lat, 1, 5, "start latency");
    chk_in(busy_len, acs_pkg::LEN_NORM - 1, acs_pkg::LEN_NORM + 1, "normal length");
    chk_in(smp_at, acs_pkg::SMP_NORM - 2, acs_pkg::SMP_NORM + 1, "normal sample");
    rd_reg(4'h3, d);
    chk(d, code(5'h06, 2'h2), "normal result");
    wr_reg(4'h2, 16'h0001);
    $display("test normal conversion done");
    // differential conversion after the gain stage settles
    wr_reg(4'h1, 16'h0008);
    repeat (12500) @(posedge clk);
    wr_reg(4'h0, 16'h0023);
    wait_idle();
    chk_in(busy_len, acs_pkg::LEN_NORM - 1, acs_pkg::LEN_DIFF + 1, "diff length");
    chk({15'h0000, diff}, 16'h0001, "diff mode");
    wr_reg(4'h2, 16'h0001);
    $display("test differential done");
    // free running: channel change lands one result late, restarts take 14
    wr_reg(4'h0, 16'h002F);
    wait_done();
    wr_reg(4'h1, 16'h0009);
    wr_reg(4'h2, 16'h0001);
    wait_done();
    rd_reg(4'h3, d);
    chk(d, code(5'h08, 2'h0), "old channel result");
    wr_reg(4'h2, 16'h0001);
    wait_done();
    rd_reg(4'h3, d);
    chk(d, code(5'h09, 2'h0), "new channel result");
    chk_in(smp_gap, acs_pkg::LEN_DIFF, acs_pkg::LEN_DIFF, "free run spacing");
    wr_reg(4'h0, 16'h0000);
    repeat (2) @(posedge clk);
    rd_reg(4'h2, d);
    chk(d & 16'h000A, 16'h0000, "disabled idle");
    wr_reg(4'h2, 16'h0005);
    $display("test free running done");
    // triggered differential: invalid unless enable toggled between
    wr_reg(4'h0, 16'h0025);
    trig_pulse();
    wait_done();
    chk({15'h0000, d[2]}, 16'h0000, "extended valid");
    wr_reg(4'h2, 16'h0005);
    trig_pulse();
    chk_in(lat, 6, 10, "trigger to sample");
    wait_done();
    chk({15'h0000, d[2]}, 16'h0001, "triggered invalid");
    wr_reg(4'h2, 16'h0005);
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h0, 16'h0025);
    trig_pulse();
    wait_done();
    chk({15'h0000, d[2]}, 16'h0000, "retoggled valid");
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h2, 16'h0005);
    $display("test auto trigger done");
    // sleep start, early wake, interrupt still raised
    wr_reg(4'h0, 16'h0031);
    @(posedge clk);
    halt <= 1'b1;
    repeat (6) @(posedge clk);
    halt <= 1'b0;
    @(negedge clk);
    chk({15'h0000, busy}, 16'h0001, "sleep start");
    wait_idle();
    @(negedge clk);
    chk({15'h0000, irq}, 16'h0001, "irq after wake");
    rd_reg(4'h0, d);
    chk(d, 16'h0031, "enable kept");
    wr_reg(4'h2, 16'h0001);
    @(posedge clk);
    @(negedge clk);
    chk({15'h0000, irq}, 16'h0000, "irq cleared");
    $display("test sleep done");
    summarize();
  end
endmodule
`default_nettype wire
